// File: rtl/module_init_sequencer.sv
// Power-up and data path initialization sequencer of a pluggable module.
// Assumes host pins are synchronous to CLK; control writes arrive as strobes.
// Flags clear on a one-cycle read pulse from the host; there is no register map here.
// Overview of operation
// - On reset load defaults: SW request 0, HW allowed 1, deinit 00h, tx controls 0.
// - At start-up copy default path config into active and staged set 0.
// - On entering reduced power set module state changed flag, then wait.
// - In reduced power, low-power signal false moves to power ramp.
// - Ramp completion enters operational state and sets module state changed flag.
// - Operational and deinit signal false: paths initialize from active set.
// - Initialized and deactivate signal false: paths go to tx turn-on, enable tx.
// - Each path entering active sets its state changed flag bit to 1.
// - Host reads all flags on interrupt; the read deasserts the interrupt.
// - Host clearing HW low-power allowed requests transition to high power.
// - With defaults, the low-power pin must be asserted to hold in reduced power.
`timescale 1ns/1ps
`default_nettype none
module module_init_sequencer
    import init_seq_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic LOW_POWER_REQUEST_PIN,
    input wire logic MODULE_SELECT_PIN,
    input wire logic CTRL_WRITE,
    input wire host_ctrl_s CTRL_DATA,
    input wire logic FLAG_READ,
    output logic INTERRUPT_N,
    output host_ctrl_s CTRL_STATE,
    output module_state_e MODULE_STATE,
    output datapath_state_e DATAPATH_STATE,
    output logic MODULE_STATE_CHANGED_FLAG,
    output logic [NUM_PATHS-1:0] DATAPATH_STATE_CHANGED_FLAG,
    output logic [NUM_PATHS-1:0] TX_ENABLE,
    output logic [7:0] ACTIVE_CONFIG,
    output logic [7:0] STAGED_CONFIG
);
    // ****************************************
    // Transition signals
    // ****************************************
    logic low_power_transition_signal;
    logic datapath_teardown_transition_signal;
    logic datapath_off_transition_signal;
    logic module_flag_set;
    logic [NUM_PATHS-1:0] path_flag_set;
    logic [11:0] ramp_count;
    logic [2:0] init_count;

    // These feed the state machines, and the low-power one also feeds the module flag set; none of them reaches a port directly.
    // Low power is held while software asks, or hardware asks and is allowed.
    // Clearing the allow bit makes the pin count for nothing, which is how software takes over.
    assign low_power_transition_signal = CTRL_STATE.sw_low_power_request |
        (CTRL_STATE.hw_low_power_request_allowed & LOW_POWER_REQUEST_PIN);
    // Any deinit bit holds every path down, since all paths move as one.
    assign datapath_teardown_transition_signal = low_power_transition_signal |
        (|CTRL_STATE.datapath_deinit_bits);
    // A disabled transmitter keeps paths short of turn-on without tearing them down.
    assign datapath_off_transition_signal = datapath_teardown_transition_signal |
        (|CTRL_STATE.tx_output_disable);

    // Host control bits; defaults load at reset, host writes replace them.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            // These defaults let the pin alone hold the module in reduced power.
            CTRL_STATE.sw_low_power_request <= SW_REQ_DEFAULT;
            CTRL_STATE.hw_low_power_request_allowed <= HW_ALLOW_DEFAULT;
            CTRL_STATE.datapath_deinit_bits <= DEINIT_DEFAULT;
            CTRL_STATE.tx_output_disable <= TXDIS_DEFAULT;
            CTRL_STATE.tx_squelch_force <= SQUELCH_DEFAULT;
        end else if (CTRL_WRITE) begin
            // The whole word is taken at once; there are no partial writes.
            CTRL_STATE <= CTRL_DATA;
        end
    end

    // ****************************************
    // Module state machine
    // ****************************************
    // Start-up lasts one cycle, enough to copy the default configuration.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            MODULE_STATE <= mgmt_startup_state;
            ramp_count <= CNT_ZERO;
            ACTIVE_CONFIG <= CONFIG_RESET;
            STAGED_CONFIG <= CONFIG_RESET;
        end else begin
            case (MODULE_STATE)
                mgmt_startup_state: begin
                    // Paths stay off here; their machine waits for the operational state.
                    ACTIVE_CONFIG <= CONFIG_DEFAULT;
                    STAGED_CONFIG <= CONFIG_DEFAULT;
                    MODULE_STATE <= module_reduced_power_state;
                end
                module_reduced_power_state: begin
                    // Wait for the host; the pin and control bits decide when to leave.
                    if (!low_power_transition_signal) begin
                        MODULE_STATE <= module_power_ramp_state;
                        ramp_count <= CNT_ZERO;
                    end
                end
                module_power_ramp_state: begin
                    // The ramp time models supply settling; it is a fixed wait.
                    if (ramp_count == RAMP_LAST) begin
                        MODULE_STATE <= module_operational_state;
                    end else begin
                        ramp_count <= ramp_count + 12'h001;
                    end
                end
                module_operational_state: begin
                    // A new low-power request drops back; the flag logic marks that entry.
                    if (low_power_transition_signal) begin
                        MODULE_STATE <= module_reduced_power_state;
                    end
                end
                default: begin
                    MODULE_STATE <= mgmt_startup_state;
                end
            endcase
        end
    end

    // ****************************************
    // Data path state machine
    // ****************************************
    // All paths move together; deinitialization is outside this block, so
    // leaving the operational state simply returns paths to off.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            DATAPATH_STATE <= datapath_off_state;
            init_count <= INIT_ZERO;
            TX_ENABLE <= '0;
        end else if (MODULE_STATE != module_operational_state) begin
            // Outside the operational state no path may carry traffic.
            DATAPATH_STATE <= datapath_off_state;
            TX_ENABLE <= '0;
        end else begin
            case (DATAPATH_STATE)
                datapath_off_state: begin
                    // Leave only once no deinit or low-power request remains.
                    if (!datapath_teardown_transition_signal) begin
                        DATAPATH_STATE <= datapath_starting_state;
                        init_count <= INIT_ZERO;
                    end
                end
                datapath_starting_state: begin
                    // Configure from ACTIVE_CONFIG over a short fixed interval.
                    // The active set is loaded at start-up, so only time passes here.
                    if (init_count == INIT_LAST) begin
                        DATAPATH_STATE <= datapath_configured_state;
                    end else begin
                        init_count <= init_count + 3'h1;
                    end
                end
                datapath_configured_state: begin
                    // Hold here while any transmitter is disabled.
                    if (!datapath_off_transition_signal) begin
                        DATAPATH_STATE <= datapath_tx_enabling_state;
                    end
                end
                datapath_tx_enabling_state: begin
                    // Squelched lanes stay quiet; every other transmit output turns on.
                    TX_ENABLE <= ~CTRL_STATE.tx_squelch_force;
                    DATAPATH_STATE <= datapath_live_state;
                end
                datapath_live_state: begin
                    // A disable or teardown request turns the transmitters off first.
                    if (datapath_off_transition_signal) begin
                        DATAPATH_STATE <= datapath_configured_state;
                        TX_ENABLE <= '0;
                    end
                end
                default: begin
                    DATAPATH_STATE <= datapath_off_state;
                end
            endcase
        end
    end

    // ****************************************
    // Flags and interrupt
    // ****************************************
    // Flag set events, taken on state entry.
    // Reduced power is entered from start-up or from the operational state.
    assign module_flag_set = (MODULE_STATE == mgmt_startup_state) ||
        ((MODULE_STATE == module_power_ramp_state) && (ramp_count == RAMP_LAST)) ||
        ((MODULE_STATE == module_operational_state) && low_power_transition_signal);

    // One set line per path; the paths share a state, so all rise together.
    generate
        for (genvar i = 0; i < NUM_PATHS; i++) begin : g_path
            assign path_flag_set[i] = (MODULE_STATE == module_operational_state) &&
                (DATAPATH_STATE == datapath_tx_enabling_state);
        end
    endgenerate

    // A read clears the flags, but a set in the same cycle wins so no event is lost.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            MODULE_STATE_CHANGED_FLAG <= 1'b0;
            DATAPATH_STATE_CHANGED_FLAG <= '0;
        end else begin
            MODULE_STATE_CHANGED_FLAG <= module_flag_set |
                (MODULE_STATE_CHANGED_FLAG & ~FLAG_READ);
            DATAPATH_STATE_CHANGED_FLAG <= path_flag_set |
                (DATAPATH_STATE_CHANGED_FLAG & {NUM_PATHS{~FLAG_READ}});
        end
    end

    // Interrupt follows the next flag values so it drops with the read.
    // Working from next values rather than the flag registers saves a cycle of lag.
    // The line is a level, not a pulse: it stays low until every flag is read.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            INTERRUPT_N <= 1'b1;
        end else begin
            INTERRUPT_N <= ~(module_flag_set | (|path_flag_set) |
                (~FLAG_READ & (MODULE_STATE_CHANGED_FLAG | (|DATAPATH_STATE_CHANGED_FLAG))));
        end
    end
endmodule : module_init_sequencer
`default_nettype wire

// File: pkg/init_seq_pkg.sv
// Package for the module initialization sequencer.
// Assumes a single management clock and a synchronous active-high reset.
package init_seq_pkg;
    // ****************************************
    // Sizes and defaults
    // ****************************************
    localparam int NUM_PATHS = 8;
    localparam logic [7:0] DEINIT_DEFAULT = 8'h00;
    localparam logic [7:0] TXDIS_DEFAULT = 8'h00;
    localparam logic [7:0] SQUELCH_DEFAULT = 8'h00;
    localparam logic [7:0] CONFIG_DEFAULT = 8'h01; // Power-on default path configuration code.
    localparam logic SW_REQ_DEFAULT = 1'b0;
    localparam logic HW_ALLOW_DEFAULT = 1'b1;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam int RAMP_TIME_US = 10;
    localparam int CLK_MHZ = 20;
    localparam int RAMP_CYCLES = RAMP_TIME_US * CLK_MHZ;
    localparam logic [11:0] RAMP_LAST = 12'(RAMP_CYCLES - 1);
    localparam logic [11:0] CNT_ZERO = 12'h000;
    localparam logic [2:0] INIT_LAST = 3'h3;
    localparam logic [2:0] INIT_ZERO = 3'h0;

    // ****************************************
    // States
    // ****************************************
    typedef enum logic [2:0] {
        mgmt_startup_state,
        module_reduced_power_state,
        module_power_ramp_state,
        module_operational_state
    } module_state_e;

    typedef enum logic [2:0] {
        datapath_off_state,
        datapath_starting_state,
        datapath_configured_state,
        datapath_tx_enabling_state,
        datapath_live_state
    } datapath_state_e;

    // Host-facing control bits travel together.
    typedef struct packed {
        logic sw_low_power_request;
        logic hw_low_power_request_allowed;
        logic [7:0] datapath_deinit_bits;
        logic [7:0] tx_output_disable;
        logic [7:0] tx_squelch_force;
    } host_ctrl_s;
endpackage : init_seq_pkg

// File: bench/init_seq_monitor.sv
// Checker for the module initialization sequencer, bound to its top ports.
// Assumes the package ramp and init counts match the bound instance.
`timescale 1ns/1ps
`default_nettype none
module init_seq_monitor
    import init_seq_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic LOW_POWER_REQUEST_PIN,
    input wire logic FLAG_READ,
    input wire logic INTERRUPT_N,
    input wire host_ctrl_s CTRL_STATE,
    input wire module_state_e MODULE_STATE,
    input wire datapath_state_e DATAPATH_STATE,
    input wire logic MODULE_STATE_CHANGED_FLAG,
    input wire logic [NUM_PATHS-1:0] DATAPATH_STATE_CHANGED_FLAG,
    input wire logic [NUM_PATHS-1:0] TX_ENABLE,
    input wire logic [7:0] ACTIVE_CONFIG,
    input wire logic [7:0] STAGED_CONFIG
);
    // ********************
    // Transition signals
    // ********************
    // Built from the registered controls, which is what the state machines act on.
    logic low_pwr;
    logic teardown;
    logic dp_off;
    assign low_pwr = CTRL_STATE.sw_low_power_request |
        (CTRL_STATE.hw_low_power_request_allowed & LOW_POWER_REQUEST_PIN);
    assign teardown = low_pwr | (|CTRL_STATE.datapath_deinit_bits);
    assign dp_off = teardown | (|CTRL_STATE.tx_output_disable);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // Each property except p_defaults and p_int ties a state move or flag to its cause with the exact cycle count.
    property p_defaults; $fell(SYS_RST) |-> CTRL_STATE == 26'h1000000
        && MODULE_STATE == mgmt_startup_state; endproperty
    a_defaults: assert property (p_defaults) else $error("control defaults wrong");
    property p_startup; MODULE_STATE == mgmt_startup_state |=> MODULE_STATE == module_reduced_power_state
        && ACTIVE_CONFIG == CONFIG_DEFAULT && STAGED_CONFIG == CONFIG_DEFAULT && DATAPATH_STATE == datapath_off_state; endproperty
    a_startup: assert property (p_startup) else $error("start-up copy wrong");
    property p_enter_low; MODULE_STATE == module_reduced_power_state
        && $past(MODULE_STATE) != module_reduced_power_state
        |-> MODULE_STATE_CHANGED_FLAG && !INTERRUPT_N; endproperty
    a_enter_low: assert property (p_enter_low) else $error("no flag on reduced power");
    property p_leave_low; MODULE_STATE == module_reduced_power_state && !low_pwr
        |=> MODULE_STATE == module_power_ramp_state; endproperty
    a_leave_low: assert property (p_leave_low) else $error("no power ramp");
    property p_ramp; MODULE_STATE == module_power_ramp_state && $past(MODULE_STATE) != module_power_ramp_state
        |-> ##199 MODULE_STATE == module_power_ramp_state
        ##1 MODULE_STATE == module_operational_state && MODULE_STATE_CHANGED_FLAG; endproperty
    a_ramp: assert property (p_ramp) else $error("ramp length or flag wrong");
    property p_dp_start; MODULE_STATE == module_operational_state && DATAPATH_STATE == datapath_off_state && !teardown
        |=> DATAPATH_STATE == datapath_starting_state ##4 DATAPATH_STATE == datapath_configured_state; endproperty
    a_dp_start: assert property (p_dp_start) else $error("path init wrong");
    property p_tx_on; DATAPATH_STATE == datapath_configured_state && !dp_off
        |=> DATAPATH_STATE == datapath_tx_enabling_state
        ##1 DATAPATH_STATE == datapath_live_state && TX_ENABLE == ~CTRL_STATE.tx_squelch_force; endproperty
    a_tx_on: assert property (p_tx_on) else $error("tx turn-on wrong");
    property p_live_flag; DATAPATH_STATE == datapath_live_state && $past(DATAPATH_STATE) != datapath_live_state
        |-> DATAPATH_STATE_CHANGED_FLAG == {NUM_PATHS{1'b1}}; endproperty
    a_live_flag: assert property (p_live_flag) else $error("path flags not set");
    property p_int; INTERRUPT_N == !(MODULE_STATE_CHANGED_FLAG || (|DATAPATH_STATE_CHANGED_FLAG)); endproperty
    a_int: assert property (p_int) else $error("interrupt level wrong");
    property p_read; FLAG_READ && (MODULE_STATE == module_reduced_power_state && low_pwr
        || DATAPATH_STATE == datapath_live_state && !dp_off)
        |=> INTERRUPT_N && !MODULE_STATE_CHANGED_FLAG; endproperty
    a_read: assert property (p_read) else $error("read did not clear");
    c_ready: cover property (MODULE_STATE == module_operational_state);
    c_live: cover property (DATAPATH_STATE == datapath_live_state);
    c_read: cover property (FLAG_READ ##1 INTERRUPT_N);
endmodule : init_seq_monitor
bind module_init_sequencer init_seq_monitor u_mon (.*);
`default_nettype wire

// File: bench/host_model.sv
// Host-side model: drives the low-power and select pins, reads flags on interrupt.
// Assumes the bench changes hold and auto_read by non-blocking assignment.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk,
    input wire logic int_n,
    input wire logic hold,
    input wire logic auto_read,
    output logic lp_pin,
    output logic sel_pin,
    output logic flag_read
);
    // Pins come up asserted so the module waits in reduced power.
    initial begin
        lp_pin = 1'b1;
        sel_pin = 1'b1;
        flag_read = 1'b0;
    end
    // Changes land on the falling edge, clear of the sampling edge.
    always @(negedge clk) begin
        lp_pin <= hold;
        // One read per interrupt; the guard stops a double pulse.
        flag_read <= auto_read && !int_n && !flag_read;
    end
endmodule : host_model
`default_nettype wire

// File: bench/module_init_sequencer_tb.sv
// Self-checking bench for the module initialization sequencer.
// Assumes a 50 ns clock and the package ramp and init counts.
`timescale 1ns/1ps
`default_nettype none
module module_init_sequencer_tb
    import init_seq_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ctrl_write = 1'b0;
    host_ctrl_s ctrl_data = '0;
    logic hold = 1'b1;
    logic auto_read = 1'b0;
    logic lp_pin, sel_pin, flag_read, int_n, msc_flag;
    host_ctrl_s ctrl_state;
    module_state_e mod_state;
    datapath_state_e dp_state;
    logic [NUM_PATHS-1:0] dp_flag, tx_en;
    logic [7:0] act_cfg, stg_cfg;
    int error_cnt = 0;
    int checked = 0;
    int n;
    always #25 clk = ~clk;
    module_init_sequencer uut (.CLK(clk), .SYS_RST(rst), .LOW_POWER_REQUEST_PIN(lp_pin), .MODULE_SELECT_PIN(sel_pin),
        .CTRL_WRITE(ctrl_write), .CTRL_DATA(ctrl_data), .FLAG_READ(flag_read), .INTERRUPT_N(int_n),
        .CTRL_STATE(ctrl_state), .MODULE_STATE(mod_state), .DATAPATH_STATE(dp_state),
        .MODULE_STATE_CHANGED_FLAG(msc_flag), .DATAPATH_STATE_CHANGED_FLAG(dp_flag), .TX_ENABLE(tx_en),
        .ACTIVE_CONFIG(act_cfg), .STAGED_CONFIG(stg_cfg));
    host_model host (.clk(clk), .int_n(int_n), .hold(hold), .auto_read(auto_read), .lp_pin(lp_pin),
        .sel_pin(sel_pin), .flag_read(flag_read));
    // ********************
    // Tasks
    // ********************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // A write is a one-cycle strobe raised and dropped on falling edges.
    task automatic write_ctrl(input host_ctrl_s d);
        @(negedge clk);
        ctrl_data = d;
        ctrl_write = 1'b1;
        @(negedge clk);
        ctrl_write = 1'b0;
    endtask : write_ctrl
    // Bounded wait; a hang shows up as a count of 400 in the caller's compare.
    task automatic wait_state(input bit on_dp, input logic [2:0] v, output int cnt);
        cnt = 0;
        while (((on_dp ? dp_state : mod_state) !== v) && cnt < 400) begin
            @(negedge clk);
            cnt++;
        end
    endtask : wait_state
    task automatic print_verdict();
        if (error_cnt == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    // The whole walk needs about 250 cycles, so 2000 means a hang.
    initial begin
        #(2000 * 50);
        error_cnt++;
        print_verdict();
    end
    // ********************
    // Start-up, power ramp, path bring-up, return to reduced power
    // ********************
    initial begin
        repeat (6) @(negedge clk);
        chk(ctrl_state, 32'h1000000);
        rst = 1'b0;
        @(negedge clk);
        chk(mod_state, module_reduced_power_state);
        chk({act_cfg, stg_cfg, 5'h0, dp_state}, {CONFIG_DEFAULT, CONFIG_DEFAULT, 8'h00});
        chk({msc_flag, int_n}, 2'b10);
        repeat (20) @(negedge clk);
        chk({mod_state, int_n}, {module_reduced_power_state, 1'b0});
        chk(stg_cfg, CONFIG_DEFAULT);
        auto_read <= 1'b1;
        repeat (2) @(negedge clk);
        chk({msc_flag, int_n}, 2'b01);
        write_ctrl(host_ctrl_s'{1'b0, 1'b0, 8'h00, 8'h00, 8'h5a});
        @(negedge clk);
        chk(mod_state, module_power_ramp_state);
        wait_state(1'b0, module_operational_state, n);
        chk(n, 200);
        chk(msc_flag, 1'b1);
        wait_state(1'b1, datapath_live_state, n);
        chk(n, 7);
        chk(act_cfg, CONFIG_DEFAULT);
        chk(tx_en, 8'ha5);
        chk({dp_flag, int_n}, 9'h1fe);
        @(negedge clk);
        chk({dp_flag, int_n}, 9'h001);
        write_ctrl(host_ctrl_s'{1'b1, 1'b0, 8'h00, 8'h00, 8'h5a});
        wait_state(1'b0, module_reduced_power_state, n);
        chk(n, 1);
        chk({msc_flag, int_n}, 2'b10);
        // Paths follow the module state one cycle later, and the host read clears the flag.
        @(negedge clk);
        chk({dp_state, tx_en}, {datapath_off_state, 8'h00});
        chk({msc_flag, int_n}, 2'b01);
        print_verdict();
    end
endmodule : module_init_sequencer_tb
`default_nettype wire
